// file: logic/ioa_defines.vh
`ifndef IOA_DEFINES_VH
`define IOA_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define IOA_REG_CTRL 8'h00
`define IOA_REG_FPTR 8'h04
`define IOA_REG_BANK 8'h08
`define IOA_REG_ACC 8'h0C
`define IOA_REG_FLAGS 8'h10
`define IOA_REG_INSTR 8'h14
`define IOA_REG_DADDR 8'h18
`define IOA_REG_MADDR 8'h1C
`define IOA_REG_MDATA 8'h20
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define IOA_CTRL_EXT_BIT 0
`define IOA_CTRL_RESET 1'b0
`define IOA_FLAG_N 4
`define IOA_FLAG_OVERFLOW 3
`define IOA_FLAG_Z 2
`define IOA_FLAG_DIGIT 1
`define IOA_FLAG_C 0
`define IOA_INSTR_BAD_BIT 16
`define IOA_INSTR_IDX_BIT 17
`define IOA_OP_D_BIT 9
`define IOA_OP_A_BIT 8
`define IOA_OFS_MAX 8'h5F
`define IOA_ACCESS_HI 4'hF
// ----------------------------------------
// Opcode patterns (upper bits, d/a/b masked out)
// ----------------------------------------
`define IOA_OPC_ADD 6'h09
`define IOA_OPC_BSET 4'h8
`define IOA_OPC_FILL 7'h34
`define IOA_FILL_VALUE 8'hFF
`endif

// file: logic/ioa_core.v
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "ioa_defines.vh"

module ioa_core (
  input wire pclk, // 125 MHz clock
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  output wire busy // Instruction cycle in progress
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [7:0] mem [0:4095];
  reg ext_en_q;
  reg [11:0] fptr_q;
  reg [3:0] bank_q;
  reg [7:0] acc_q;
  reg [4:0] flags_q;
  reg [15:0] opcode_q;
  reg bad_q;
  reg idx_q;
  reg [11:0] daddr_q;
  reg [11:0] maddr_q;
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [7:0] rdat_q;
  reg [7:0] res_q;
  reg [4:0] nflags_q;
  reg wr_mem_q;
  reg wr_acc_q;
  reg wr_flags_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] rd_mux;
  reg rd_ok;
  reg [12:0] dec_addr;
  reg is_add;
  reg is_bset;
  reg is_fill;
  reg [8:0] sum9;
  reg [4:0] nib_sum;
  wire apb_done;
  wire apb_wr;
  wire [7:0] bit_mask;

  // ----------------------------------------
  // Quarter-cycle states, one-hot
  // ----------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_Q1 = 5'h02;
  localparam [4:0] ST_Q2 = 5'h04;
  localparam [4:0] ST_Q3 = 5'h08;
  localparam [4:0] ST_Q4 = 5'h10;

  // ----------------------------------------
  // Address decode function
  // ----------------------------------------
  // Returns {indexed, data address}
  function [12:0] ioa_data_addr;
    input ext;
    input acc_bit;
    input [7:0] f;
    input [11:0] fp;
    input [3:0] bank;
    begin
      if (ext && !acc_bit && (f <= `IOA_OFS_MAX))
        ioa_data_addr = {1'b1, fp + {4'h0, f}};
      else if (!acc_bit)
        ioa_data_addr = {1'b0, (f <= `IOA_OFS_MAX) ? 4'h0 : `IOA_ACCESS_HI, f};
      else
        ioa_data_addr = {1'b0, bank, f};
    end
  endfunction

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  assign apb_done = psel && penable && pready_q;
  assign apb_wr = apb_done && pwrite && !pslverr_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign busy = (state_q != ST_IDLE);

  // Read mux and address check
  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (paddr)
      `IOA_REG_CTRL: rd_mux = {31'h0, ext_en_q};
      `IOA_REG_FPTR: rd_mux = {20'h0, fptr_q};
      `IOA_REG_BANK: rd_mux = {28'h0, bank_q};
      `IOA_REG_ACC: rd_mux = {24'h0, acc_q};
      `IOA_REG_FLAGS: rd_mux = {27'h0, flags_q};
      `IOA_REG_INSTR: rd_mux = {14'h0, idx_q, bad_q, opcode_q};
      `IOA_REG_DADDR: rd_mux = {20'h0, daddr_q};
      `IOA_REG_MADDR: rd_mux = {20'h0, maddr_q};
      `IOA_REG_MDATA: rd_mux = {24'h0, mem[maddr_q]};
      default: rd_ok = 1'b0;
    endcase
  end

  // Ready one cycle after request, held off while executing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (pready_q)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (psel && !busy)
    begin
      pready_q <= 1'b1;
      pslverr_q <= !rd_ok;
      prdata_q <= (pwrite || !rd_ok) ? 32'h0000_0000 : rd_mux;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_en_q <= `IOA_CTRL_RESET;
      fptr_q <= 12'h000;
      bank_q <= 4'h0;
      maddr_q <= 12'h000;
      opcode_q <= 16'h0000;
    end
    else if (apb_wr)
    begin
      case (paddr)
        `IOA_REG_CTRL: ext_en_q <= pwdata[`IOA_CTRL_EXT_BIT];
        `IOA_REG_FPTR: fptr_q <= pwdata[11:0];
        `IOA_REG_BANK: bank_q <= pwdata[3:0];
        `IOA_REG_MADDR: maddr_q <= pwdata[11:0];
        `IOA_REG_INSTR: opcode_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Quarter-cycle sequencer
  // ----------------------------------------
  // four quarters per instruction
  always @*
  begin
    case (state_q)
      ST_IDLE: state_d = (apb_wr && paddr == `IOA_REG_INSTR) ? ST_Q1 : ST_IDLE;
      ST_Q1: state_d = ST_Q2;
      ST_Q2: state_d = ST_Q3;
      ST_Q3: state_d = ST_Q4;
      ST_Q4: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // indexed form ignores bank choice
  always @*
  begin
    dec_addr = ioa_data_addr(ext_en_q, opcode_q[`IOA_OP_A_BIT], opcode_q[7:0], fptr_q, bank_q);
    is_add = (opcode_q[15:10] == `IOA_OPC_ADD);
    is_bset = (opcode_q[15:12] == `IOA_OPC_BSET);
    is_fill = (opcode_q[15:9] == `IOA_OPC_FILL);
  end

  assign bit_mask = 8'h01 << opcode_q[11:9];

  // Add with nibble carry
  always @*
  begin
    sum9 = {1'b0, acc_q} + {1'b0, rdat_q};
    nib_sum = {1'b0, acc_q[3:0]} + {1'b0, rdat_q[3:0]};
  end

  // ----------------------------------------
  // Execute
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bad_q <= 1'b0;
      idx_q <= 1'b0;
      daddr_q <= 12'h000;
      rdat_q <= 8'h00;
      res_q <= 8'h00;
      nflags_q <= 5'h00;
      wr_mem_q <= 1'b0;
      wr_acc_q <= 1'b0;
      wr_flags_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        // Q1 decode and address
        ST_Q1:
        begin
          daddr_q <= dec_addr[11:0];
          idx_q <= dec_addr[12];
          bad_q <= !(is_add || is_bset || is_fill);
          wr_acc_q <= is_add && !opcode_q[`IOA_OP_D_BIT];
          wr_mem_q <= is_bset || is_fill || (is_add && opcode_q[`IOA_OP_D_BIT]);
          wr_flags_q <= is_add;
        end
        // Q2 operand read
        ST_Q2:
          rdat_q <= mem[daddr_q];
        // Q3 process
        ST_Q3:
        begin
          if (is_add)
          begin
            res_q <= sum9[7:0];
            nflags_q[`IOA_FLAG_N] <= sum9[7];
            nflags_q[`IOA_FLAG_OVERFLOW] <= (acc_q[7] == rdat_q[7]) && (sum9[7] != acc_q[7]);
            nflags_q[`IOA_FLAG_Z] <= (sum9[7:0] == 8'h00);
            nflags_q[`IOA_FLAG_DIGIT] <= nib_sum[4];
            nflags_q[`IOA_FLAG_C] <= sum9[8];
          end
          else if (is_bset)
            res_q <= rdat_q | bit_mask;
          else
            res_q <= `IOA_FILL_VALUE;
        end
        default: ;
      endcase
    end
  end

  // Accumulator and flags, Q4 or software
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q <= 8'h00;
      flags_q <= 5'h00;
    end
    else if (state_q == ST_Q4)
    begin
      if (wr_acc_q)
        acc_q <= res_q;
      if (wr_flags_q)
        flags_q <= nflags_q;
    end
    else if (apb_wr && paddr == `IOA_REG_ACC)
      acc_q <= pwdata[7:0];
    else if (apb_wr && paddr == `IOA_REG_FLAGS)
      flags_q <= pwdata[4:0];
  end

  // ----------------------------------------
  // Data memory
  // ----------------------------------------
  always @(posedge pclk)
  begin
    if (state_q == ST_Q4 && wr_mem_q)
      mem[daddr_q] <= res_q;
    else if (apb_wr && paddr == `IOA_REG_MDATA)
      mem[maddr_q] <= pwdata[7:0];
  end

endmodule

`default_nettype wire

// file: dv/ioa_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Bus and instruction cycle checks
// ----------------------------------------
module ioa_monitor (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic busy // Executing
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Steps of one instruction
  sequence instr_write_s;
    psel && penable && pready && pwrite && paddr == 8'h14;
  endsequence
  sequence quarters_s;
    busy [*4] ##1 !busy;
  endsequence
  quarter_run_a: assert property ($rose(busy) |-> quarters_s)
    else $error("busy not four cycles");
  instr_start_a: assert property (instr_write_s |=> busy)
    else $error("no start after write");
  busy_cause_a: assert property ($rose(busy) |-> $past(pwrite && paddr == 8'h14))
    else $error("busy without write");
  stall_busy_a: assert property (busy |-> !pready)
    else $error("answer while busy");
  setup_answer_a: assert property (psel && !penable && !busy |=> pready)
    else $error("late answer");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  unmapped_err_a: assert property (psel && pready && paddr > 8'h20 |-> pslverr)
    else $error("unmapped not refused");
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, busy, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  int mismatches = 0, check_count = 0, cyc = 0;
  // Clock
  always #4 pclk = ~pclk;
  ioa_core ioa_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task test_done;
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
      mismatches++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task put(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, 8'h1C, {20'h0, a});
    apb(1'b1, 8'h20, {24'h0, d});
  endtask
  task peek(input logic [11:0] a, input logic [7:0] x);
    apb(1'b1, 8'h1C, {20'h0, a});
    rd(8'h20, {24'h0, x});
  endtask
  task exec(input logic [15:0] op, input logic [11:0] x);
    apb(1'b1, 8'h14, {16'h0, op});
    rd(8'h18, {20'h0, x});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_add;
    rd(8'h00, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h04, 32'hA00);
    apb(1'b1, 8'h0C, 32'h17);
    put(12'hA2C, 8'h20);
    exec(16'h242C, 12'hA2C);
    rd(8'h0C, 32'h37);
    rd(8'h10, 32'h0);
    peek(12'hA2C, 8'h20);
    apb(1'b1, 8'h04, 32'hFE0);
    put(12'h03F, 8'hC9);
    exec(16'h265F, 12'h03F);
    rd(8'h0C, 32'h37);
    rd(8'h10, 32'h07);
    peek(12'h03F, 8'h00);
  endtask
  task t_bset;
    apb(1'b1, 8'h04, 32'hA00);
    apb(1'b1, 8'h10, 32'h1F);
    put(12'hA0A, 8'h00);
    for (int b = 0; b < 8; b++)
    begin
      exec(16'h800A | 16'(b << 9), 12'hA0A);
      peek(12'hA0A, 8'((2 << b) - 1));
    end
    rd(8'h10, 32'h1F);
  endtask
  task t_fill;
    put(12'hA2C, 8'h00);
    apb(1'b1, 8'h10, 32'h0A);
    exec(16'h682C, 12'hA2C);
    rd(8'h14, 32'h2682C);
    peek(12'hA2C, 8'hFF);
    rd(8'h10, 32'h0A);
  endtask
  task t_literal;
    apb(1'b1, 8'h08, 32'h5);
    exec(16'h692C, 12'h52C);
    exec(16'h6860, 12'hF60);
    apb(1'b1, 8'h00, 32'h0);
    exec(16'h682C, 12'h02C);
    rd(8'h14, 32'h682C);
    exec(16'h0000, 12'h000);
    rd(8'h14, 32'h10000);
    rd(8'h0C, 32'h37);
    exec(16'h692C, 12'h52C);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  // Timeout guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      mismatches++;
      test_done;
    end
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_add;
    t_bset;
    t_fill;
    t_literal;
    test_done;
  end
endmodule
bind ioa_core ioa_monitor ioa_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy(busy));
`default_nettype wire
